// ==== core/pila_pkg.sv ====
// package: constants and carrier types of the irq line aggregator
package pila_pkg;
  localparam int NSRC   = 24;
  localparam int FLAG_W = 8;
  localparam int NLINE  = 32;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // per-source register block: stride 16 bytes, three words used
  localparam logic [ADDR_W-1:0] SRC_STRIDE  = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_FLAG    = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_ENSET   = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_ENCLR   = 10'h008;
  // aggregator registers
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 10'h200;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 10'h204;
  localparam logic [ADDR_W-1:0] OFS_LINES   = 10'h208;
  // reset values
  localparam logic [FLAG_W-1:0] FLAG_RST    = 8'h00;
  localparam logic [FLAG_W-1:0] EN_RST      = 8'h00;
  localparam logic [NLINE-1:0]  STATUS_RST  = 32'h00000000;
  localparam logic [NLINE-1:0]  MASK_RST    = 32'h00000000;
  // source order: power mgr, main clock, osc ctrl, slow osc ctrl, supply,
  // protection, watchdog, rtc, ext irq, freq meter, nvm, dma, event sys,
  // serial 0..3, control timer 0, timer 0..2, adc, comparator, touch
  localparam logic [4:0] SRC_LINE [NSRC] = '{
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
    5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h11, 5'h14, 5'h15, 5'h16,
    5'h19, 5'h1B, 5'h1E};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pila_bus_t;
endpackage

// ==== core/pila_aggregator.sv ====
// top: per-peripheral flags, enables and vectored line mapping
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - a peripheral event sets its flag bit whatever the enable state
// - writing one to enable-set enables that source; zero leaves it
// - writing one to enable-clear disables that source; zero leaves it
// - request only while some flag is set together with its own enable
// - all gated requests of one peripheral are ORed into one request
// - the external non-maskable source drives the core nmi input
// - power, clock, oscillators, supply and protection share line 0
// - watchdog drives line 1, real-time clock line 2
// - maskable external irq drives line 3, frequency meter line 4
// - nvm controller line 6, dma line 7, event system line 8
// - serial controllers 0 to 3 drive lines 9 to 12 in order
// - control timer 0 line 17; timers 0,1,2 lines 20,21,22
// - adc line 25, analog comparator line 27, touch line 30
module pila_aggregator
  import pila_pkg::*;
(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  // register port
  input  wire pila_bus_t                     i_bus,
  output logic      [DATA_W-1:0]             o_rdata,
  // peripheral events, one-cycle pulses per flag
  input  wire logic [NSRC-1:0][FLAG_W-1:0]   i_events,
  input  wire logic                          i_ext_nmi,
  // toward the core controller
  output logic      [NLINE-1:0]              o_lines,
  output logic                               o_nmi,
  output logic                               o_irq
);

  function automatic logic src_hit(input logic [ADDR_W-1:0] a,
                                   input int s,
                                   input logic [ADDR_W-1:0] ofs);
    logic [ADDR_W-1:0] base;
    base = ADDR_W'(s * 16);
    return a == (base + ofs);
  endfunction

  logic [FLAG_W-1:0] flag_ff   [NSRC];
  logic [FLAG_W-1:0] en_ff     [NSRC];
  logic [NSRC-1:0]   req_ff;
  logic [NLINE-1:0]  line_ff;
  logic [NLINE-1:0]  nxt_line;
  logic [NLINE-1:0]  status_ff;
  logic [NLINE-1:0]  mask_ff;
  logic              nmi_ff;
  logic              irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  genvar s;
  generate
    for (s = 0; s < NSRC; s++)
    begin : g_src
      logic [FLAG_W-1:0] clr;
      assign clr = (i_bus.wr && src_hit(i_bus.addr, s, OFS_FLAG)) ?
                   i_bus.wdata[FLAG_W-1:0] : FLAG_RST;

      // an event in the clearing cycle survives
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
          flag_ff[s] <= FLAG_RST;
        else
          flag_ff[s] <= (flag_ff[s] & ~clr) | i_events[s];
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
          en_ff[s] <= EN_RST;
        else if (i_bus.wr && src_hit(i_bus.addr, s, OFS_ENSET))
          en_ff[s] <= en_ff[s] | i_bus.wdata[FLAG_W-1:0];
        else if (i_bus.wr && src_hit(i_bus.addr, s, OFS_ENCLR))
          en_ff[s] <= en_ff[s] & ~i_bus.wdata[FLAG_W-1:0];
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
          req_ff[s] <= 1'b0;
        else
          req_ff[s] <= |(flag_ff[s] & en_ff[s]);
      end
    end
  endgenerate

  // line map from the source table; lines nobody maps stay low
  always_comb
  begin
    nxt_line = '0;
    for (int k = 0; k < NSRC; k++)
      if (req_ff[k])
        nxt_line[SRC_LINE[k]] = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      line_ff <= '0;
    else
      line_ff <= nxt_line;
  end

  // nmi bypasses the numbered lines; source is same-clock logic
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      nmi_ff <= 1'b0;
    else
      nmi_ff <= i_ext_nmi;
  end

  // summary status: a rising line sets its bit, write one clears
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      status_ff <= STATUS_RST;
    else if (i_bus.wr && i_bus.addr == OFS_STATUS)
      status_ff <= (status_ff & ~i_bus.wdata) | (nxt_line & ~line_ff);
    else
      status_ff <= status_ff | (nxt_line & ~line_ff);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      mask_ff <= MASK_RST;
    else if (i_bus.wr && i_bus.addr == OFS_MASK)
      mask_ff <= i_bus.wdata;
  end

  // one cycle late against status, traded for a registered output
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(status_ff & mask_ff);
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = '0;
    for (int k = 0; k < NSRC; k++)
    begin
      if (src_hit(i_bus.addr, k, OFS_FLAG))
        nxt_rdata = {{(DATA_W-FLAG_W){1'b0}}, flag_ff[k]};
      if (src_hit(i_bus.addr, k, OFS_ENSET) ||
          src_hit(i_bus.addr, k, OFS_ENCLR))
        nxt_rdata = {{(DATA_W-FLAG_W){1'b0}}, en_ff[k]};
    end
    if (i_bus.addr == OFS_STATUS)
      nxt_rdata = status_ff;
    if (i_bus.addr == OFS_MASK)
      nxt_rdata = mask_ff;
    if (i_bus.addr == OFS_LINES)
      nxt_rdata = line_ff;
    if (!i_bus.rd)
      nxt_rdata = '0;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;
  assign o_lines = line_ff;
  assign o_nmi   = nmi_ff;
  assign o_irq   = irq_ff;

endmodule
`default_nettype wire

// ==== dv/pila_aggregator_properties.sv ====
// checker: port-level properties of the irq line aggregator
`timescale 1ns/1ps
`default_nettype none
module pila_props
  import pila_pkg::*;
(
  input wire logic                        i_clk,
  input wire logic                        i_resetn,
  input wire pila_bus_t                   i_bus,
  input wire logic [NSRC-1:0][FLAG_W-1:0] i_events,
  input wire logic                        i_ext_nmi,
  input wire logic [NLINE-1:0]            o_lines,
  input wire logic                        o_nmi,
  input wire logic                        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_nmi_follow: assert property
    ($past(i_resetn) |-> o_nmi == $past(i_ext_nmi)) else $error("nmi");
  chk_spare_lines: assert property
    ((o_lines & 32'hB58DE020) == 32'h0) else $error("spare line");
  chk_reset_clear: assert property
    (!$past(i_resetn) |-> o_lines == 32'h0 && !o_irq) else $error("rst");
  chk_shared_line: assert property
    ($rose(o_lines[0]) |-> $past(|i_events[5:0] || i_bus.wr, 3))
    else $error("line 0");
  chk_wdog_line: assert property
    ($rose(o_lines[1]) |-> $past(|i_events[6] || i_bus.wr, 3))
    else $error("line 1");
  chk_ctl_timer: assert property
    ($rose(o_lines[17]) |-> $past(|i_events[17] || i_bus.wr, 3))
    else $error("line 17");
  chk_touch_line: assert property
    ($rose(o_lines[30]) |-> $past(|i_events[23] || i_bus.wr, 3))
    else $error("line 30");
  chk_line_fall: assert property
    ($fell(o_lines[9]) |-> $past(i_bus.wr, 3)) else $error("line 9");
endmodule
bind pila_aggregator pila_props pila_props_inst (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_bus(i_bus), .i_events(i_events),
  .i_ext_nmi(i_ext_nmi), .o_lines(o_lines), .o_nmi(o_nmi), .o_irq(o_irq));
`default_nettype wire

// ==== dv/pila_core_model.sv ====
// partner: pending bits of the core vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pila_core_model
  import pila_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [NLINE-1:0] i_lines,
  input  wire logic [NLINE-1:0] i_ena,
  output logic      [NLINE-1:0] o_pend,
  output logic      [NLINE-1:0] o_active
);
  // priority fields per line, held at reset level in this model
  logic [1:0] prio_ff [NLINE];
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn) prio_ff <= '{default: 2'h0};
    else prio_ff <= prio_ff;
  // a pending line goes active only while its enable is set
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn) o_active <= '0;
    else o_active <= o_pend & i_ena;
  // pending is never cleared here: the bench checks accumulation only
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn) o_pend <= '0;
    else o_pend <= o_pend | i_lines;
endmodule
`default_nettype wire

// ==== dv/test_peripheral_irq_line_aggregator.sv ====
// testbench: line mapping, enables, status and nmi of the aggregator
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_irq_line_aggregator
  import pila_pkg::*;
;
  logic                        i_clk = 0, i_resetn = 0, i_ext_nmi = 0;
  pila_bus_t                   i_bus = '0;
  logic [NSRC-1:0][FLAG_W-1:0] i_events = '0;
  logic [DATA_W-1:0]           o_rdata, q[$];
  logic [NLINE-1:0]            o_lines, o_pend, st = '0;
  logic                        o_nmi, o_irq, rd_d = 0, nmi_d = 0;
  logic [NLINE-1:0]            o_active, ena = 32'h0000FFFF;
  int                          error_cnt = 0, n_checks = 0, b;
  int                          seed = 32'h599081c3;
  pila_aggregator pila_aggregator_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_events(i_events),
    .i_ext_nmi(i_ext_nmi), .o_lines(o_lines), .o_nmi(o_nmi), .o_irq(o_irq));
  pila_core_model pila_core_model_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_lines(o_lines), .i_ena(ena), .o_pend(o_pend),
    .o_active(o_active));
  task automatic chk(string n, logic [DATA_W-1:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // every call drives the whole bus, so no signal is assigned twice a step
  task automatic drive(logic w, r, int a, logic [DATA_W-1:0] d, int s, f);
    logic [NSRC-1:0][FLAG_W-1:0] e;
    e = '0;
    if (s >= 0) e[s][f] = 1'b1;
    i_bus <= '{w, r, ADDR_W'(a), d};
    i_events <= e;
    i_ext_nmi <= 1'($random(seed));
    @(posedge i_clk);
  endtask
  task automatic wr(int a, logic [DATA_W-1:0] d);
    drive(1, 0, a, d, -1, 0);
  endtask
  task automatic rd(int a, logic [DATA_W-1:0] e);
    q.push_back(e);
    drive(0, 1, a, 32'h0, -1, 0);
  endtask
  task automatic idle(int n);
    repeat (n) drive(0, 0, 0, 32'h0, -1, 0);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0 && q.size() == 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    rd_d <= i_bus.rd;
    nmi_d <= i_ext_nmi;
    if (i_resetn) chk("nmi", 32'(nmi_d), 32'(o_nmi));
    if (rd_d) chk("rdata", q.pop_front(), o_rdata);
  end
  initial
    forever #2.5 i_clk = ~i_clk;
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    idle(1);
    for (int s = 0; s < NSRC; s++)
    begin
      b = $unsigned($random(seed)) % FLAG_W;
      st[SRC_LINE[s]] = 1'b1;
      drive(0, 0, 0, 32'h0, s, b);
      idle(3);
      rd(s*16, 32'h1 << b);
      rd(OFS_LINES, 32'h0);
      wr(s*16+4, 32'h0);
      idle(1);
      rd(s*16+4, 32'h0);
      wr(s*16+4, 32'h1 << b);
      wr(s*16+8, 32'h0);
      idle(3);
      rd(OFS_LINES, 32'h1 << SRC_LINE[s]);
      wr(s*16+8, 32'h1 << b);
      wr(s*16, 32'h1 << b);
      idle(3);
      rd(OFS_LINES, 32'h0);
    end
    rd(OFS_STATUS, st);
    wr(OFS_MASK, 32'h2);
    idle(3);
    chk("irq", 32'h1, 32'(o_irq));
    wr(OFS_STATUS, 32'hFFFFFFFF);
    idle(3);
    chk("irq", 32'h0, 32'(o_irq));
    chk("pend", st, o_pend);
    chk("active", st & 32'h0000FFFF, o_active);
    rd(10'h300, 32'h0);
    idle(2);
    summarize();
  end
endmodule
`default_nettype wire
